// ### design/conv_if.sv
/*
  Carrier between the control block and its settling timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface conv_if #(parameter int CNT_W = 24);
  logic run;
  logic restart;
  logic tick;
  logic repeat_mode;
  logic [CNT_W-1:0] settle_len;
  logic [CNT_W-1:0] period_len;
  logic done;
  modport ctrl (output run, restart, tick, repeat_mode, settle_len, period_len, input done);
  modport timer (input run, restart, tick, repeat_mode, settle_len, period_len, output done);
endinterface

// ### design/sd_ctrl_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  sigma-delta mode, clock and filter control block.
  Assumes it is included by bare name from the design files.
*/
`ifndef SD_CTRL_MAP_SVH
`define SD_CTRL_MAP_SVH

// register indices; byte address is four times the index
`define SD_IDX_MODE 6'h01
`define SD_IDX_CHAN 6'h02
`define SD_IDX_SETUP0 6'h03
`define SD_IDX_FILT0 6'h05
`define SD_IDX_STATUS 6'h07

// converter_mode_control fields
`define SD_MODE_RESET 16'h8000
`define SD_MODE_WMASK 16'ha77c
`define SD_MODE_REF_EN 15
`define SD_MODE_SINGLE_CYCLE_SETTLE 13
`define SD_MODE_OP_LSB 4
`define SD_MODE_CLK_LSB 2
`define SD_OP_CONTINUOUS 3'h0
`define SD_OP_SINGLE 3'h1
`define SD_OP_STANDBY 3'h2

// master_clock_source_select codes
`define SD_CLK_INT 2'h0
`define SD_CLK_INT_OUT 2'h1
`define SD_CLK_EXT 2'h2
`define SD_CLK_XTAL 2'h3

// setup and filter registers
`define SD_SETUP_RESET 8'h20
`define SD_SETUP_REF_LSB 4
`define SD_FILT_RESET 32'h00000000
`define SD_FILT_TYPE_LSB 16
`define SD_FLT_SINC5_1 2'h0
`define SD_FLT_SINC3 2'h1
`define SD_FLT_ENH 2'h2

// channel register: enables in [1:0], setup pick per channel from bit 4
`define SD_CHAN_RESET 8'h01
`define SD_CHAN_SETUP_LSB 4

// filter timing: clock in Hz, rates in samples per second, latency in sinc5 periods, sinc3 settling in output periods
`define SD_MCLK_HZ 16000000
`define SD_SINC5_SPS 250000
`define SD_SINC5_DECIM (`SD_MCLK_HZ / `SD_SINC5_SPS)
`define SD_SINGLE_CYC_MAX_SPS 10000
`define SD_SINGLE_CYC_MIN_AVG (`SD_SINC5_SPS / `SD_SINGLE_CYC_MAX_SPS)
`define SD_SINC5_LATENCY 4
`define SD_SINC3_PERIODS 3

`endif

// ### design/sd_ctrl_pkg.sv
/*
  Types of the settling timer; the control block uses none of them.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sd_ctrl_pkg;
  typedef enum {TMR_IDLE, TMR_SETTLE, TMR_REPEAT} tmr_state_e;
  typedef logic [1:0] setup_ref_t;
endpackage

// ### design/sd_mode_ctrl.sv
/*
  Mode, master clock and filter control of a multiplexed sigma-delta
  converter, with an APB register slave.
  Assumes clock pins are asynchronous levels and are oversampled at
  40 MHz; the master clock is seen as one tick per rising edge.
*/
`timescale 1ns/100ps
`include "sd_ctrl_map.svh"
module sd_mode_ctrl #(
  parameter int CNT_W = 24,
  parameter int NUM_SETUP = 2
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // clock pins
  input wire logic OSC_CLK_I,
  input wire logic XTAL_CLK_I,
  input wire logic CLOCK_IN_OUT_PIN_I,
  output logic CLOCK_IN_OUT_PIN_O,
  output logic CLOCK_IN_OUT_PIN_OE_N_O,
  // converter control
  output logic REF_OUT_EN_O,
  output logic [1:0] REF_SRC_SEL_O,
  output logic [1:0] MCLK_SRC_O,
  output logic [1:0] FILTER_TYPE_O,
  output logic ACTIVE_CHAN_O,
  output logic CONV_DONE_O
);
  conv_if #(.CNT_W(CNT_W)) cv ();

  // pin synchronisers: 0 oscillator, 1 crystal, 2 clock in/out pin
  logic [2:0] pin_raw;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  assign pin_raw = {CLOCK_IN_OUT_PIN_I, XTAL_CLK_I, OSC_CLK_I};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  // registers
  logic [15:0] mode_ff, nxt_mode;
  logic [7:0] chan_ff, nxt_chan;
  logic [7:0] setup_ff [NUM_SETUP];
  logic [7:0] nxt_setup [NUM_SETUP];
  logic [31:0] filt_ff [NUM_SETUP];
  logic [31:0] nxt_filt [NUM_SETUP];
  logic ready_ff, nxt_ready;
  logic act_ch_ff, nxt_act_ch;
  logic [31:0] rdata_ff, nxt_rdata;
  logic sel_prev_ff, nxt_sel_prev;
  logic restart_ff, nxt_restart;
  logic clock_in_out_pin_ff, nxt_clock_in_out_pin;
  logic clock_in_out_pin_oe_n_ff, nxt_clock_in_out_pin_oe_n;

  // apb decode
  logic [5:0] idx;
  logic setup_phase, access;
  logic wr_acc, rd_acc, mapped;
  logic hit_mode, hit_chan, hit_status;
  logic [NUM_SETUP-1:0] hit_setup, hit_filt;
  logic [31:0] bmask;

  assign idx = PADDR_I[7:2];
  assign setup_phase = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I;
  assign hit_mode = (idx == `SD_IDX_MODE);
  assign hit_chan = (idx == `SD_IDX_CHAN);
  assign hit_status = (idx == `SD_IDX_STATUS);
  generate
    for (gi = 0; gi < NUM_SETUP; gi++) begin : g_hit
      assign hit_setup[gi] = (idx == `SD_IDX_SETUP0 + 6'(gi));
      assign hit_filt[gi] = (idx == `SD_IDX_FILT0 + 6'(gi));
    end
  endgenerate
  assign mapped = (PADDR_I[1:0] == 2'h0) &
    (hit_mode | hit_chan | hit_status | (|hit_setup) | (|hit_filt));
  assign wr_acc = access & PWRITE_I & mapped;
  assign rd_acc = access & ~PWRITE_I & mapped;
  assign bmask = {{8{PSTRB_I[3]}}, {8{PSTRB_I[2]}}, {8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};

  // zero wait states; read data was captured in the setup cycle
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access & ~mapped;
  assign PRDATA_O = rdata_ff;

  // active setup and filter
  logic multi, run_op;
  logic act_setup;
  logic [1:0] clk_sel;
  logic [1:0] flt;
  logic [15:0] avg;
  logic [CNT_W-1:0] n_avg, period, settle;

  assign clk_sel = mode_ff[`SD_MODE_CLK_LSB +: 2];
  assign multi = chan_ff[0] & chan_ff[1];
  assign act_setup = chan_ff[`SD_CHAN_SETUP_LSB + int'(act_ch_ff)];
  assign flt = filt_ff[act_setup][`SD_FILT_TYPE_LSB +: 2];
  assign avg = filt_ff[act_setup][15:0];
  assign n_avg = CNT_W'(avg) + CNT_W'(1);
  assign period = CNT_W'(n_avg * CNT_W'(`SD_SINC5_DECIM));

  always_comb begin
    settle = period;
    case (flt)
      `SD_FLT_SINC3: settle = CNT_W'(period * CNT_W'(`SD_SINC3_PERIODS));
      `SD_FLT_ENH: settle = period;
      default: begin
        if (n_avg < CNT_W'(`SD_SINGLE_CYC_MIN_AVG)) begin
          settle = period + CNT_W'(`SD_SINC5_LATENCY * `SD_SINC5_DECIM);
        end
      end
    endcase
  end

  assign run_op = (mode_ff[`SD_MODE_OP_LSB +: 3] == `SD_OP_CONTINUOUS) |
    (mode_ff[`SD_MODE_OP_LSB +: 3] == `SD_OP_SINGLE);

  logic sel_lvl;
  always_comb begin
    case (clk_sel)
      `SD_CLK_EXT: sel_lvl = sync2_ff[2];
      `SD_CLK_XTAL: sel_lvl = sync2_ff[1];
      default: sel_lvl = sync2_ff[0];
    endcase
  end

  assign cv.run = run_op & (chan_ff[0] | chan_ff[1]);
  assign cv.restart = restart_ff;
  assign cv.tick = sel_lvl & ~sel_prev_ff;
  assign cv.repeat_mode = ~mode_ff[`SD_MODE_SINGLE_CYCLE_SETTLE] & ~multi;
  assign cv.settle_len = settle;
  assign cv.period_len = period;

  sd_settle_timer #(.CNT_W(CNT_W)) u_timer (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .cv(cv.timer)
  );

  // register group
  always_comb begin
    nxt_mode = mode_ff;
    nxt_chan = chan_ff;
    nxt_ready = ready_ff;
    nxt_act_ch = act_ch_ff;
    nxt_rdata = rdata_ff;
    // reserved mode bits are never stored and read back as zero
    if (wr_acc && hit_mode) begin
      nxt_mode = (mode_ff & ~(bmask[15:0] & `SD_MODE_WMASK)) |
        (PWDATA_I[15:0] & bmask[15:0] & `SD_MODE_WMASK);
    end
    if (wr_acc && hit_chan) begin
      nxt_chan = (chan_ff & ~bmask[7:0]) | (PWDATA_I[7:0] & bmask[7:0]);
    end
    if (cv.done && mode_ff[`SD_MODE_OP_LSB +: 3] == `SD_OP_SINGLE) begin
      nxt_mode[`SD_MODE_OP_LSB +: 3] = `SD_OP_STANDBY;
    end
    // clear only what the read returned, so a result after the capture waits
    if (rd_acc && hit_status && rdata_ff[0]) begin
      nxt_ready = 1'b0;
    end
    if (cv.done) begin
      nxt_ready = 1'b1;
    end
    if (cv.done && multi) begin
      nxt_act_ch = ~act_ch_ff;
    end else if (!chan_ff[act_ch_ff]) begin
      nxt_act_ch = chan_ff[1] & ~chan_ff[0];
    end
    if (setup_phase) begin
      nxt_rdata = '0;
      if (hit_mode) nxt_rdata = {16'h0000, mode_ff};
      if (hit_chan) nxt_rdata = {24'h000000, chan_ff};
      if (hit_status) nxt_rdata = {24'h000000, 2'h0, clk_sel, 1'b0, cv.run, act_ch_ff, ready_ff};
      for (int i = 0; i < NUM_SETUP; i++) begin
        if (hit_setup[i]) nxt_rdata = {24'h000000, setup_ff[i]};
        if (hit_filt[i]) nxt_rdata = filt_ff[i];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      mode_ff <= `SD_MODE_RESET;
      chan_ff <= `SD_CHAN_RESET;
      ready_ff <= 1'b0;
      act_ch_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      chan_ff <= nxt_chan;
      ready_ff <= nxt_ready;
      act_ch_ff <= nxt_act_ch;
      rdata_ff <= nxt_rdata;
    end
  end

  // per-setup registers
  generate
    for (gi = 0; gi < NUM_SETUP; gi++) begin : g_setup
      always_comb begin
        nxt_setup[gi] = setup_ff[gi];
        nxt_filt[gi] = filt_ff[gi];
        if (wr_acc && hit_setup[gi]) begin
          nxt_setup[gi] = (setup_ff[gi] & ~bmask[7:0]) | (PWDATA_I[7:0] & bmask[7:0]);
        end
        if (wr_acc && hit_filt[gi]) begin
          nxt_filt[gi] = (filt_ff[gi] & ~bmask) | (PWDATA_I & bmask);
        end
      end
      always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
          setup_ff[gi] <= `SD_SETUP_RESET;
          filt_ff[gi] <= `SD_FILT_RESET;
        end else begin
          setup_ff[gi] <= nxt_setup[gi];
          filt_ff[gi] <= nxt_filt[gi];
        end
      end
    end
  endgenerate

  // clock path and restart group
  always_comb begin
    nxt_sel_prev = sel_lvl;
    // new settings or a channel switch start a fresh settling period
    nxt_restart = wr_acc | (cv.done & multi);
    nxt_clock_in_out_pin = (clk_sel == `SD_CLK_INT_OUT) ? sync2_ff[0] : 1'b0;
    nxt_clock_in_out_pin_oe_n = (clk_sel != `SD_CLK_INT_OUT);
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      sel_prev_ff <= 1'b0;
      restart_ff <= 1'b0;
      clock_in_out_pin_ff <= 1'b0;
      clock_in_out_pin_oe_n_ff <= 1'b1;
    end else begin
      sel_prev_ff <= nxt_sel_prev;
      restart_ff <= nxt_restart;
      clock_in_out_pin_ff <= nxt_clock_in_out_pin;
      clock_in_out_pin_oe_n_ff <= nxt_clock_in_out_pin_oe_n;
    end
  end

  assign CLOCK_IN_OUT_PIN_O = clock_in_out_pin_ff;
  assign CLOCK_IN_OUT_PIN_OE_N_O = clock_in_out_pin_oe_n_ff;
  assign REF_OUT_EN_O = mode_ff[`SD_MODE_REF_EN];
  assign REF_SRC_SEL_O = setup_ff[act_setup][`SD_SETUP_REF_LSB +: 2];
  assign MCLK_SRC_O = clk_sel;
  assign FILTER_TYPE_O = flt;
  assign ACTIVE_CHAN_O = act_ch_ff;
  assign CONV_DONE_O = cv.done;
endmodule

// ### design/sd_settle_timer.sv
/*
  Settling and output-rate timer: counts master clock ticks and marks
  each finished conversion with a one-cycle pulse.
  Assumes the tick is a one-cycle pulse per master clock rising edge.
*/
`timescale 1ns/100ps
module sd_settle_timer #(
  parameter int CNT_W = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control side
  conv_if.timer cv
);
  sd_ctrl_pkg::tmr_state_e state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;

  assign cv.done = done_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (!cv.run) begin
      nxt_state = sd_ctrl_pkg::TMR_IDLE;
    end else if (cv.restart) begin
      nxt_state = sd_ctrl_pkg::TMR_SETTLE;
      nxt_cnt = cv.settle_len;
    end else begin
      case (state_ff)
        sd_ctrl_pkg::TMR_IDLE: begin
          nxt_state = sd_ctrl_pkg::TMR_SETTLE;
          nxt_cnt = cv.settle_len;
        end
        sd_ctrl_pkg::TMR_SETTLE, sd_ctrl_pkg::TMR_REPEAT: begin
          if (cv.tick) begin
            if (cnt_ff <= CNT_W'(1)) begin
              nxt_done = 1'b1;
              if (cv.repeat_mode) begin
                nxt_state = sd_ctrl_pkg::TMR_REPEAT;
                nxt_cnt = cv.period_len;
              end else begin
                nxt_state = sd_ctrl_pkg::TMR_SETTLE;
                nxt_cnt = cv.settle_len;
              end
            end else begin
              nxt_cnt = cnt_ff - CNT_W'(1);
            end
          end
        end
        default: nxt_state = sd_ctrl_pkg::TMR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_ff <= sd_ctrl_pkg::TMR_IDLE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end
endmodule

// ### tb/sd_mode_ctrl_chk.sv
/*
  Port checker for the mode, clock and filter control block.
  Assumes binding to its top; clock pins there toggle no faster than 10 MHz.
*/
`timescale 1ns/100ps
module sd_mode_ctrl_chk (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // pins and control
  input wire logic CLOCK_IN_OUT_PIN_OE_N_O,
  input wire logic REF_OUT_EN_O,
  input wire logic [1:0] REF_SRC_SEL_O,
  input wire logic [1:0] MCLK_SRC_O,
  input wire logic [1:0] FILTER_TYPE_O,
  input wire logic CONV_DONE_O
);
  logic acc;
  logic mode_wr;
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;
  assign acc = PSEL_I && PENABLE_I;
  assign mode_wr = acc && PWRITE_I && PADDR_I == 8'h04;
  // saturates so a long quiet spell never wraps into a false short gap
  always_comb begin
    nxt_gap = (gap_ff == 16'hffff) ? gap_ff : gap_ff + 16'h0001;
    if (CONV_DONE_O) begin
      nxt_gap = 16'h0000;
    end
  end
  always_ff @(posedge CLK_I) begin
    gap_ff <= RESET_N_I ? nxt_gap : 16'hffff;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  AST_REF_FOLLOWS_WRITE: assert property (mode_wr && PSTRB_I[1] |=>
    REF_OUT_EN_O == $past(PWDATA_I[15])) else $error("reference enable missed a write");
  AST_RESET_STATE: assert property ($rose(RESET_N_I) |-> REF_OUT_EN_O &&
    MCLK_SRC_O == 2'h0 && FILTER_TYPE_O == 2'h0 && REF_SRC_SEL_O == 2'h2 && CLOCK_IN_OUT_PIN_OE_N_O)
    else $error("wrong state after reset");
  AST_CLKSEL_FOLLOWS_WRITE: assert property (mode_wr && PSTRB_I[0] |=>
    MCLK_SRC_O == $past(PWDATA_I[3:2])) else $error("clock select missed a write");
  AST_CLKOUT_ON: assert property ((MCLK_SRC_O == 2'h1) [*2] |-> !CLOCK_IN_OUT_PIN_OE_N_O)
    else $error("clock out not driven");
  AST_CLKOUT_OFF: assert property ((MCLK_SRC_O != 2'h1) [*2] |-> CLOCK_IN_OUT_PIN_OE_N_O)
    else $error("clock pin driven outside clock out mode");
  AST_DONE_PULSE: assert property (CONV_DONE_O |=> !CONV_DONE_O)
    else $error("result strobe longer than one cycle");
  AST_RATE_FLOOR: assert property (CONV_DONE_O |-> gap_ff >= 16'h00fa)
    else $error("results closer than the sinc5 rate allows");
  AST_MODE_READBACK: assert property (acc && !PWRITE_I && PADDR_I == 8'h04 |->
    (PRDATA_O & 32'hffff5883) == 32'h0 && PRDATA_O[15] == REF_OUT_EN_O &&
    PRDATA_O[3:2] == MCLK_SRC_O) else $error("mode read back wrong");
  AST_BAD_ADDR: assert property (acc |-> PREADY_O && PSLVERR_O == (PADDR_I[1:0] != 2'h0 ||
    PADDR_I[7:2] == 6'h00 || PADDR_I[7:2] > 6'h07)) else $error("wrong slave error");
  AST_ERR_IN_ACCESS: assert property (PSLVERR_O |-> acc)
    else $error("slave error outside access");
endmodule
bind sd_mode_ctrl sd_mode_ctrl_chk chk_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .CLOCK_IN_OUT_PIN_OE_N_O(CLOCK_IN_OUT_PIN_OE_N_O), .REF_OUT_EN_O(REF_OUT_EN_O),
  .REF_SRC_SEL_O(REF_SRC_SEL_O), .MCLK_SRC_O(MCLK_SRC_O), .FILTER_TYPE_O(FILTER_TYPE_O),
  .CONV_DONE_O(CONV_DONE_O));

// ### tb/test_sigma_delta_mode_clock_filter_ctrl.sv
/*
  Self-checking bench of the mode, clock and filter control block.
  Assumes the design files and the register map header are compiled first.
*/
`timescale 1ns/100ps
`include "sd_ctrl_map.svh"
module test_sigma_delta_mode_clock_filter_ctrl;
  logic CLK_I = 1'b0;
  logic RESET_N_I = 1'b0;
  logic PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0;
  logic [3:0] PSTRB_I = 4'h0;
  logic OSC_CLK_I = 1'b0, XTAL_CLK_I = 1'b0, ext_lvl = 1'b0;
  wire CLOCK_IN_OUT_PIN_I;
  logic [31:0] PRDATA_O, rd_v, mode_m;
  logic PREADY_O, PSLVERR_O, CLOCK_IN_OUT_PIN_O, CLOCK_IN_OUT_PIN_OE_N_O, REF_OUT_EN_O, ACTIVE_CHAN_O;
  logic CONV_DONE_O, er_v;
  logic [1:0] REF_SRC_SEL_O, MCLK_SRC_O, FILTER_TYPE_O;
  logic [2:0] pc = 3'h0, xc = 3'h0;
  int err_count = 0;
  int n_checks = 0;
  logic [7:0] ra[4] = '{8'h04, 8'h08, 8'h0c, 8'h14};
  logic [31:0] rx[4] = '{32'h8000, 32'h01, 32'h20, 32'h0};
  logic [31:0] tf[9] = '{32'h0, 32'h0, 32'h10000, 32'h20000, 32'h18, 32'h17, 32'h0, 32'h0, 32'h0};
  logic ts[9] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [1:0] tc[9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h1};

  sd_mode_ctrl dut_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .OSC_CLK_I(OSC_CLK_I), .XTAL_CLK_I(XTAL_CLK_I), .CLOCK_IN_OUT_PIN_I(CLOCK_IN_OUT_PIN_I), .CLOCK_IN_OUT_PIN_O(CLOCK_IN_OUT_PIN_O),
    .CLOCK_IN_OUT_PIN_OE_N_O(CLOCK_IN_OUT_PIN_OE_N_O), .REF_OUT_EN_O(REF_OUT_EN_O), .REF_SRC_SEL_O(REF_SRC_SEL_O),
    .MCLK_SRC_O(MCLK_SRC_O), .FILTER_TYPE_O(FILTER_TYPE_O), .ACTIVE_CHAN_O(ACTIVE_CHAN_O),
    .CONV_DONE_O(CONV_DONE_O));

  initial begin
    forever #12.5 CLK_I = ~CLK_I;
  end
  // pin level seen by the block: its own driver wins while enabled
  assign CLOCK_IN_OUT_PIN_I = CLOCK_IN_OUT_PIN_OE_N_O ? ext_lvl : CLOCK_IN_OUT_PIN_O;
  // oscillator 4, crystal 6, external 8 bench cycles per period
  always @(posedge CLK_I) begin
    pc <= pc + 3'h1;
    xc <= (xc == 3'h5) ? 3'h0 : xc + 3'h1;
    OSC_CLK_I <= pc[1];
    ext_lvl <= pc[2];
    XTAL_CLK_I <= xc < 3'h3;
  end

  function automatic int tk(logic [1:0] c);
    return (c == `SD_CLK_EXT) ? 8 : (c == `SD_CLK_XTAL) ? 6 : 4;
  endfunction
  function automatic int exp_ticks(logic [1:0] t, int avg, logic each);
    int p;
    int s;
    p = (avg + 1) * `SD_SINC5_DECIM;
    s = (avg + 1 >= `SD_SINGLE_CYC_MIN_AVG) ? p : p + `SD_SINC5_LATENCY * `SD_SINC5_DECIM;
    if (t == `SD_FLT_SINC3) s = `SD_SINC3_PERIODS * p;
    if (t == `SD_FLT_ENH) s = p;
    return each ? s : p;
  endfunction
  function automatic logic [31:0] exp_mode(logic [31:0] o, logic [31:0] d, logic [3:0] s);
    logic [31:0] m;
    m = {16'h0000, {8{s[1]}}, {8{s[0]}}};
    return ((o & ~m) | (d & m)) & {16'h0000, `SD_MODE_WMASK};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PADDR_I <= a;
    PWRITE_I <= w;
    PWDATA_I <= d;
    PSTRB_I <= w ? s : 4'h0;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'h0, 32'h1, "bus answer timeout");
      report_and_stop();
    end
    rd = PRDATA_O;
    er = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask
  task automatic wait_done(output int c);
    c = 0;
    do begin
      @(posedge CLK_I);
      c++;
    end while (CONV_DONE_O !== 1'b1 && c < 20000);
    if (c >= 20000) begin
      chk(32'h0, 32'h1, "no result");
      report_and_stop();
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [3:0] s;
    logic ch;
    logic [3:0] ck;
    int g;
    int e;
    void'($urandom(4603));
    repeat (2) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    foreach (ra[i]) begin
      apb(ra[i], 1'b0, 32'h0, 4'h0, rd_v, er_v);
      chk(rd_v, rx[i], "reset value");
    end
    rd_v = 32'({REF_OUT_EN_O, MCLK_SRC_O, FILTER_TYPE_O, REF_SRC_SEL_O});
    chk(rd_v, 32'h42, "reset pins");
    mode_m = 32'h8000;
    // op field kept at continuous so single-shot cannot rewrite it underneath
    // reserved bits written as zero
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'h0000a70c : $urandom() & 32'h0000a70c;
      s = (i == 0) ? 4'hf : 4'($urandom());
      apb(8'h04, 1'b1, d, s, rd_v, er_v);
      mode_m = exp_mode(mode_m, d, s);
      apb(8'h04, 1'b0, 32'h0, 4'h0, rd_v, er_v);
      chk(rd_v, mode_m, "mode read back");
      chk(32'(REF_OUT_EN_O), 32'(mode_m[15]), "reference enable");
      chk(32'(MCLK_SRC_O), 32'(mode_m[3:2]), "clock select");
      chk(32'(CLOCK_IN_OUT_PIN_OE_N_O), 32'(mode_m[3:2] != `SD_CLK_INT_OUT), "clock pin enable");
    end
    apb(8'h3c, 1'b0, 32'h0, 4'h0, rd_v, er_v);
    chk(32'(er_v), 32'h1, "unmapped read error");
    chk(rd_v, 32'h0, "unmapped read");
    apb(8'h05, 1'b1, 32'h0, 4'hf, rd_v, er_v);
    apb(8'h04, 1'b0, 32'h0, 4'h0, rd_v, er_v);
    chk(rd_v, mode_m, "misaligned write ignored");
    // only one channel is enabled while sinc3 is selected
    for (int i = 0; i < 9; i++) begin
      apb(8'h14, 1'b1, tf[i], 4'hf, rd_v, er_v);
      d = 32'h8000 | (32'(ts[i]) << 13) | (32'(tc[i]) << 2);
      apb(8'h04, 1'b1, d, 4'hf, rd_v, er_v);
      repeat (4) @(posedge CLK_I);
      wait_done(g);
      wait_done(g);
      e = tk(tc[i]) * exp_ticks(tf[i][17:16], int'(tf[i][15:0]), ts[i]);
      chk(g, e, "spacing");
      chk(32'(FILTER_TYPE_O), 32'(tf[i][17:16]), "filter type");
      chk(32'(CLOCK_IN_OUT_PIN_OE_N_O), 32'(tc[i] != `SD_CLK_INT_OUT), "clock pin enable");
      for (int k = 0; k < 4; k++) begin
        @(posedge CLK_I);
        ck = {ck[2:0], CLOCK_IN_OUT_PIN_O};
      end
      chk(32'($countones(ck)), (tc[i] == `SD_CLK_INT_OUT) ? 32'h2 : 32'h0, "clock out pin");
    end
    apb(8'h04, 1'b1, 32'h8000, 4'hf, rd_v, er_v);
    apb(8'h14, 1'b1, 32'h0, 4'hf, rd_v, er_v);
    apb(8'h18, 1'b1, 32'h1, 4'hf, rd_v, er_v);
    apb(8'h10, 1'b1, 32'h0, 4'hf, rd_v, er_v);
    apb(8'h08, 1'b1, 32'h23, 4'hf, rd_v, er_v);
    repeat (4) @(posedge CLK_I);
    wait_done(g);
    for (int i = 0; i < 4; i++) begin
      repeat (3) @(posedge CLK_I);
      ch = ACTIVE_CHAN_O;
      chk(32'(REF_SRC_SEL_O), ch ? 32'h0 : 32'h2, "reference of active setup");
      wait_done(g);
      chk(g + 3, 4 * exp_ticks(`SD_FLT_SINC5_1, int'(ch), 1'b1), "scan spacing");
    end
    // single-shot: one result, then the op field parks in standby
    apb(8'h04, 1'b1, 32'h8020, 4'hf, rd_v, er_v);
    apb(8'h08, 1'b1, 32'h01, 4'hf, rd_v, er_v);
    repeat (2) apb(8'h1c, 1'b0, 32'h0, 4'h0, rd_v, er_v);
    chk(rd_v, 32'h0, "status idle");
    apb(8'h04, 1'b1, 32'h8010, 4'hf, rd_v, er_v);
    wait_done(g);
    apb(8'h04, 1'b0, 32'h0, 4'h0, rd_v, er_v);
    chk(rd_v, 32'h8020, "single shot parks in standby");
    apb(8'h1c, 1'b0, 32'h0, 4'h0, rd_v, er_v);
    chk(rd_v, 32'h01, "status result ready");
    apb(8'h1c, 1'b0, 32'h0, 4'h0, rd_v, er_v);
    chk(rd_v, 32'h0, "status cleared by read");
    RESET_N_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    apb(8'h04, 1'b0, 32'h0, 4'h0, rd_v, er_v);
    chk(rd_v, 32'h8000, "mode after second reset");
    report_and_stop();
  end
endmodule
